// ==== core/rtcp_pkg.sv ====
// Constants, types and helpers of the clock prescale and vector block
// Function
// - Alarm day bit 7 enables that field
// - BCD tens 5-4, units 3-0, bit 6 zero
// - Control bits 15-5 read zero, ignore writes
// - Timer 0 interval code selects divide 2..256
// - Timer 1 has same interval field encoding
// - Timer 0 bit 1 gates its interrupt; here it gates only the vector source, irq ignores it
// - Bit 0 flag set by interval event, writable
// - Timer 1 enable also enables deep wake-up
// - Timer 1 flag usable as wake-up event
// - Settings retained while deep sleep lock holds; only interval and wake enable are held, vector gating uses live enable
// - Timer 0 count readable and writable, 8 bits
// - Timer 1 count readable and writable, 8 bits
// - Vector resets zero, zero when none pending
// - Vector codes 02h..0Ch, ready highest priority
// - Smallest pending code reported, 0Ch lowest
package rtcp_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned TICK_HZ = 1_000_000;
    localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

    localparam logic [7:0] OFS_ALARM = 8'h00;
    localparam logic [7:0] OFS_CTL [2] = '{8'h04, 8'h08};
    localparam logic [7:0] OFS_CNT [2] = '{8'h0c, 8'h10};
    localparam logic [7:0] OFS_VEC = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_MASK = 8'h1c;

    localparam int ALARM_EN_BIT = 7;
    localparam int ALARM_DAY_MSB = 5;
    localparam int CTL_IVL_LSB = 2;
    localparam int CTL_IVL_MSB = 4;
    localparam int CTL_IE_BIT = 1;
    localparam int CTL_FLAG_BIT = 0;

    localparam logic [5:0] ALARM_DAY_RST = 6'h00;
    localparam logic [2:0] IVL_RST = 3'h0;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [1:0] STAT_RST = 2'h0;

    localparam int NSRC = 6;
    localparam int SRC_PS0 = 3;
    localparam int SRC_PS1 = 4;
    localparam logic [15:0] VEC_NONE = 16'h0000;
    localparam logic [15:0] VEC_CODE [NSRC] = '{16'h0002, 16'h0004,
        16'h0006, 16'h0008, 16'h000a, 16'h000c};
    localparam logic [15:0] VEC_RESERVED = 16'h000e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } rtcp_apb_state_t;

    // Low bits that must all be one for an interval event
    function automatic logic [7:0] rtcp_ivl_mask(input logic [2:0] sel);
        logic [15:0] m;
        m = (16'h0002 << sel) - 16'h0001;
        return m[7:0];
    endfunction
endpackage

// ==== core/rtcp_ps_if.sv ====
// Link between the register block and one prescale counter
interface rtcp_ps_if;
    logic tick;
    logic [2:0] interval;
    logic load;
    logic [7:0] load_value;
    logic [7:0] count;
    logic interval_event;
    modport timer (input tick, interval, load, load_value,
                   output count, interval_event);
    modport ctrl (output tick, interval, load, load_value,
                  input count, interval_event);
endinterface

// ==== core/rtcp_prescaler.sv ====
// One 8-bit prescale counter with interval event
module rtcp_prescaler (
    input wire logic clk,
    input wire logic reset_n,
    rtcp_ps_if.timer ps
);
    import rtcp_pkg::*;

    logic [7:0] count;
    logic [7:0] next_count;
    wire [7:0] ivl_mask = rtcp_ivl_mask(ps.interval);

    assign next_count = ps.load ? ps.load_value :
                        ps.tick ? count + 8'h01 : count;
    assign ps.interval_event = ps.tick && !ps.load &&
                               ((count & ivl_mask) == ivl_mask);
    assign ps.count = count;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= CNT_RST;
        end else begin
            count <= next_count;
        end
    end

    property p_event_wraps;
        logic [7:0] m;
        @(posedge clk) disable iff (!reset_n)
        (ps.interval_event, m = ivl_mask) |=> ((count & m) == 8'h00);
    endproperty
    a_event_wraps: assert property (p_event_wraps)
        else $error("interval event did not wrap selected bits");

    property p_load_value;
        @(posedge clk) disable iff (!reset_n)
        ps.load |=> (count == $past(ps.load_value));
    endproperty
    a_load_value: assert property (p_load_value)
        else $error("counter write not taken");
endmodule

// ==== core/rtcp_top.sv ====
// Prescale timers, day alarm and interrupt vector behind APB
//
// Chosen here: the address map and the APB slave port.
module rtcp_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clock_ready_flag,
    input wire logic interval_timer_flag,
    input wire logic user_alarm_flag,
    input wire logic osc_failure_flag,
    input wire logic deep_sleep_io_lock,
    input wire logic deep_sleep_exit,
    output logic [3:0] ext_flag_clear,
    output logic alarm_field_enable,
    output logic [5:0] alarm_day_value,
    output logic deep_sleep_wake,
    output logic irq
);
    import rtcp_pkg::*;

    rtcp_apb_state_t state;
    rtcp_apb_state_t next_state;
    logic [7:0] tick_cnt;
    logic tick;
    logic [2:0] ctl_ivl [2];
    logic ctl_ie [2];
    logic flag [2];
    logic [2:0] held_ivl [2];
    logic held_ie [2];
    logic [1:0] status;
    logic [1:0] mask;
    logic vec_valid_q;
    logic [2:0] vec_idx_q;

    rtcp_ps_if ps_bus [2] ();

    // Address map check, used by the error logic only
    function automatic logic addr_hit(input logic [7:0] a);
        return a == OFS_ALARM || a == OFS_CTL[0] || a == OFS_CTL[1] ||
               a == OFS_CNT[0] || a == OFS_CNT[1] || a == OFS_VEC ||
               a == OFS_STAT || a == OFS_MASK;
    endfunction

    // Lowest index pending wins, so smallest code
    function automatic logic [3:0] pick_src(input logic [NSRC-1:0] p);
        logic [3:0] r;
        r = 4'h0;
        for (int k = NSRC - 1; k >= 0; k--) begin
            if (p[k]) begin
                r = {1'b1, 3'(k)};
            end
        end
        return r;
    endfunction

    wire access = psel && penable;
    wire done = (state == ST_ACK) && access;
    wire wr_done = done && pwrite;
    wire rd_done = done && !pwrite;
    wire wr_alarm = wr_done && (paddr == OFS_ALARM);
    wire wr_stat = wr_done && (paddr == OFS_STAT);
    wire wr_mask = wr_done && (paddr == OFS_MASK);
    wire rd_vec = rd_done && (paddr == OFS_VEC);

    wire [2:0] eff_ivl [2];
    wire eff_ie [2];
    wire ev [2];
    wire wr_ctl [2];
    wire vec_clr [2];
    wire [31:0] rd_ctl [2];
    wire [31:0] rd_cnt [2];

    // Source order: ready first, oscillator last
    wire [NSRC-1:0] pend = {osc_failure_flag,
                            flag[1] && ctl_ie[1],
                            flag[0] && ctl_ie[0],
                            user_alarm_flag,
                            interval_timer_flag,
                            clock_ready_flag};
    wire [3:0] pick = pick_src(pend);
    wire vec_valid = pick[3];
    wire [2:0] vec_idx = pick[2:0];
    wire [15:0] vec_word = vec_valid ? VEC_CODE[vec_idx] : VEC_NONE;
    wire vec_take = rd_vec && vec_valid_q;

    wire [31:0] rd_alarm = {24'h000000, alarm_field_enable, 1'b0,
                            alarm_day_value};
    wire [31:0] rd_word =
        (paddr == OFS_ALARM) ? rd_alarm :
        (paddr == OFS_CTL[0]) ? rd_ctl[0] :
        (paddr == OFS_CTL[1]) ? rd_ctl[1] :
        (paddr == OFS_CNT[0]) ? rd_cnt[0] :
        (paddr == OFS_CNT[1]) ? rd_cnt[1] :
        (paddr == OFS_VEC) ? {16'h0000, vec_word} :
        (paddr == OFS_STAT) ? {30'h0, status} :
        (paddr == OFS_MASK) ? {30'h0, mask} : 32'h00000000;

    wire [1:0] ev_bits = {ev[1], ev[0]};
    // Set beats the one-write clear
    wire [1:0] next_status = ev_bits | (status & ~(wr_stat ?
                             pwdata[1:0] : 2'h0));
    wire [3:0] next_ext_clear = vec_take ? {vec_idx_q == 3'h5,
                                            vec_idx_q == 3'h2,
                                            vec_idx_q == 3'h1,
                                            vec_idx_q == 3'h0} : 4'h0;

    assign next_state = (state == ST_IDLE && access) ? ST_ACK : ST_IDLE;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ps
            // Frozen copy used while lock holds
            assign eff_ivl[i] = deep_sleep_io_lock ? held_ivl[i] :
                                ctl_ivl[i];
            assign eff_ie[i] = deep_sleep_io_lock ? held_ie[i] :
                               ctl_ie[i];
            assign wr_ctl[i] = wr_done && (paddr == OFS_CTL[i]);
            // Read of vector clears reported flag
            assign vec_clr[i] = vec_take &&
                                (vec_idx_q == 3'(SRC_PS0 + i));
            assign rd_ctl[i] = {27'h0000000, ctl_ivl[i], ctl_ie[i],
                                flag[i]};
            assign rd_cnt[i] = {24'h000000, ps_bus[i].count};
            assign ev[i] = ps_bus[i].interval_event;
            assign ps_bus[i].interval = eff_ivl[i];
            assign ps_bus[i].tick = tick;
            assign ps_bus[i].load = wr_done && (paddr == OFS_CNT[i]);
            assign ps_bus[i].load_value = pwdata[7:0];

            rtcp_prescaler u_ps (
                .clk(clk),
                .reset_n(reset_n),
                .ps(ps_bus[i])
            );

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    ctl_ivl[i] <= IVL_RST;
                    ctl_ie[i] <= 1'b0;
                end else if (deep_sleep_exit) begin
                    ctl_ivl[i] <= IVL_RST;
                    ctl_ie[i] <= 1'b0;
                end else if (wr_ctl[i]) begin
                    ctl_ivl[i] <= pwdata[CTL_IVL_MSB:CTL_IVL_LSB];
                    ctl_ie[i] <= pwdata[CTL_IE_BIT];
                end
            end

            // Event sets, wins over any clear
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    flag[i] <= 1'b0;
                end else if (ev[i]) begin
                    flag[i] <= 1'b1;
                end else if (wr_ctl[i]) begin
                    flag[i] <= pwdata[CTL_FLAG_BIT];
                end else if (vec_clr[i] || deep_sleep_exit) begin
                    flag[i] <= 1'b0;
                end
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    held_ivl[i] <= IVL_RST;
                    held_ie[i] <= 1'b0;
                end else if (!deep_sleep_io_lock) begin
                    held_ivl[i] <= ctl_ivl[i];
                    held_ie[i] <= ctl_ie[i];
                end
            end
        end
    endgenerate

    // Common time base for both counters
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt <= 8'h00;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == TICK_LAST);
            tick_cnt <= (tick_cnt == TICK_LAST) ? 8'h00 :
                        tick_cnt + 8'h01;
        end
    end

    // One wait state keeps all bus outputs registered
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            vec_valid_q <= 1'b0;
            vec_idx_q <= 3'h0;
        end else begin
            state <= next_state;
            pready <= (next_state == ST_ACK);
            pslverr <= (next_state == ST_ACK) && !addr_hit(paddr);
            if (next_state == ST_ACK) begin
                prdata <= pwrite ? 32'h00000000 : rd_word;
                vec_valid_q <= vec_valid;
                vec_idx_q <= vec_idx;
            end
        end
    end

    // Alarm field enable and BCD day kept
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_field_enable <= 1'b0;
            alarm_day_value <= ALARM_DAY_RST;
        end else if (wr_alarm) begin
            alarm_field_enable <= pwdata[ALARM_EN_BIT];
            alarm_day_value <= pwdata[ALARM_DAY_MSB:0];
        end
    end

    // Sticky status, mask gates the level output
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status <= STAT_RST;
            mask <= STAT_RST;
            irq <= 1'b0;
            ext_flag_clear <= 4'h0;
            deep_sleep_wake <= 1'b0;
        end else begin
            status <= next_status;
            if (wr_mask) begin
                mask <= pwdata[1:0];
            end
            irq <= |(status & mask);
            ext_flag_clear <= next_ext_clear;
            // Timer 1 flag is the wake event
            deep_sleep_wake <= flag[1] && eff_ie[1];
        end
    end

    sequence s_read_of(logic [7:0] ofs);
        state == ST_ACK && access && !pwrite && paddr == ofs;
    endsequence

    property p_alarm_bit6;
        @(posedge clk) disable iff (!reset_n)
        s_read_of(OFS_ALARM) |-> (prdata[6] == 1'b0);
    endproperty
    a_alarm_bit6: assert property (p_alarm_bit6)
        else $error("alarm bit 6 not zero");

    property p_ctl_reserved;
        @(posedge clk) disable iff (!reset_n)
        (s_read_of(OFS_CTL[0]) or s_read_of(OFS_CTL[1]))
            |-> (prdata[31:5] == 27'h0000000);
    endproperty
    a_ctl_reserved: assert property (p_ctl_reserved)
        else $error("control reserved bits not zero");

    property p_flag_set;
        @(posedge clk) disable iff (!reset_n)
        ev[0] |=> flag[0] && status[0];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("timer 0 event lost");

    property p_none_pending;
        @(posedge clk) disable iff (!reset_n)
        (pend == 6'h00) |-> (vec_word == VEC_NONE);
    endproperty
    a_none_pending: assert property (p_none_pending)
        else $error("vector not zero with nothing pending");

    property p_ready_first;
        @(posedge clk) disable iff (!reset_n)
        clock_ready_flag |-> (vec_word == VEC_CODE[0]);
    endproperty
    a_ready_first: assert property (p_ready_first)
        else $error("ready not highest priority");

    property p_never_reserved;
        @(posedge clk) disable iff (!reset_n)
        (pend[SRC_PS1] && !pend[SRC_PS0]) |->
            (vec_word != VEC_RESERVED) && (vec_word <= VEC_CODE[SRC_PS1]);
    endproperty
    a_never_reserved: assert property (p_never_reserved)
        else $error("vector code out of order");

    property p_read_clears;
        @(posedge clk) disable iff (!reset_n)
        (vec_take && vec_idx_q == 3'(SRC_PS0) && !ev[0]) |=> !flag[0];
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("vector read did not clear timer 0 flag");

    property p_wake;
        @(posedge clk) disable iff (!reset_n)
        (flag[1] && eff_ie[1]) |=> deep_sleep_wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("timer 1 wake-up missing");

    property p_retained;
        @(posedge clk) disable iff (!reset_n)
        (deep_sleep_io_lock && $past(deep_sleep_io_lock))
            |-> $stable(eff_ivl[1]) && $stable(eff_ie[1]);
    endproperty
    a_retained: assert property (p_retained)
        else $error("settings changed under lock");

    property p_masked_ie;
        @(posedge clk) disable iff (!reset_n)
        (!ctl_ie[0] && !clock_ready_flag && !interval_timer_flag &&
         !user_alarm_flag) |-> (vec_word != VEC_CODE[SRC_PS0]);
    endproperty
    a_masked_ie: assert property (p_masked_ie)
        else $error("disabled timer 0 reported");
endmodule

// ==== verif/rtcp_top_tb.sv ====
// Self-checking bench for the prescale timer and vector block
module rtcp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rtcp_pkg::*;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel, penable, pwrite, lock, dexit;
    logic [7:0] paddr;
    logic [31:0] pwdata, q;
    logic [3:0] ext_f;
    logic [3:0] clr_seen = 4'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, afe, wake, irq;
    wire logic [5:0] aday;
    wire logic [3:0] fclr;
    logic e;
    int errors = 0;
    int checks = 0;

    rtcp_top uut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clock_ready_flag(ext_f[0]),
        .interval_timer_flag(ext_f[1]), .user_alarm_flag(ext_f[2]),
        .osc_failure_flag(ext_f[3]), .deep_sleep_io_lock(lock),
        .deep_sleep_exit(dexit), .ext_flag_clear(fclr),
        .alarm_field_enable(afe), .alarm_day_value(aday),
        .deep_sleep_wake(wake), .irq(irq));

    always #4 clk = ~clk;

    // Clear pulses are one cycle wide, so keep a running record
    // Held off in reset, so an unknown pulse before reset is not kept
    always @(posedge clk) begin
        if (reset_n) begin
            clr_seen <= clr_seen | fclr;
        end
    end

    task automatic end_of_test();
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            $display("[FAIL] %0t no bus answer", $time);
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Old irq level lingers two edges after a status clear
    task automatic wait_irq(input int lo, input int hi);
        int n;
        n = 0;
        cyc(2);
        while (irq !== 1'b1 && n < hi) begin
            @(posedge clk);
            n++;
        end
        if (n >= hi) begin
            errors++;
            $display("[FAIL] %0t no interval event", $time);
            end_of_test();
        end
        chk({31'h0, n >= lo}, 32'h1);
    endtask

    // Tick phase is unknown, so the window is two ticks wide below and one above
    task automatic run_ivl(input int t, input int s);
        int n;
        n = 1 << (s + 1);
        wr(OFS_MASK, 32'h1 << t);
        wr(OFS_CTL[t], 32'(s) << 2);
        wr(OFS_CNT[t], 32'h0);
        wr(OFS_STAT, 32'h3);
        wait_irq((n - 2) * 125, (n + 1) * 125 + 8);
        rd(OFS_CTL[t]);
        chk(q & 32'h1, 32'h1); // event flag set
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_f = 4'h0;
        lock = 1'b0;
        dexit = 1'b0;
        cyc(20);
        reset_n <= 1'b1;
        rd(OFS_CTL[0]);
        chk(q, 32'h0); // control resets clear
        rd(OFS_CTL[1]);
        chk(q, 32'h0); // flag resets clear
        rd(OFS_VEC);
        chk(q, 32'h0); // vector resets zero
        chk({31'h0, irq}, 32'h0); // nothing pending
        wr(OFS_ALARM, 32'hffffffff);
        rd(OFS_ALARM);
        chk(q, 32'h000000bf); // bit 6 reads zero
        chk({31'h0, afe}, 32'h1); // field enabled
        chk({26'h0, aday}, 32'h3f); // day bits kept
        wr(OFS_ALARM, 32'h31);
        rd(OFS_ALARM);
        chk(q, 32'h31); // tens 3 units 1
        chk({31'h0, afe}, 32'h0); // field excluded
        for (int t = 0; t < 2; t++) begin
            wr(OFS_CNT[t], 32'h0);
            wr(OFS_CTL[t], 32'hffffffff);
            rd(OFS_CTL[t]);
            chk(q, 32'h1f); // reserved bits read zero
        end
        cyc(2);
        chk({31'h0, wake}, 32'h1); // enable plus flag wakes
        wr(OFS_CTL[1], 32'h1e);
        cyc(2);
        chk({31'h0, wake}, 32'h0); // no flag, no wake
        wr(OFS_CTL[0], 32'h1d);
        wr(OFS_CTL[1], 32'h1c);
        rd(OFS_VEC);
        chk(q, 32'h0); // disabled flag not reported
        for (int t = 0; t < 2; t++) begin
            wr(OFS_CNT[t], 32'hffffffa5);
            rd(OFS_CNT[t]);
            // A tick may land between write and read
            chk({31'h0, q == 32'ha5 || q == 32'ha6}, 32'h1);
        end
        for (int s = 0; s < 8; s++) begin
            run_ivl(0, s); // timer 0 divide 2 to 256
        end
        for (int s = 0; s < 2; s++) begin
            run_ivl(1, s); // timer 1 same encoding
        end
        rd(OFS_STAT);
        chk(q & 32'h2, 32'h2); // status follows event
        wr(OFS_MASK, 32'h0);
        cyc(2);
        chk({31'h0, irq}, 32'h0); // masked event silent
        wr(OFS_MASK, 32'h2);
        cyc(2);
        chk({31'h0, irq}, 32'h1); // unmasked event raises
        wr(OFS_STAT, 32'h2);
        cyc(2);
        chk({31'h0, irq}, 32'h0); // write one clears
        rd(8'h20);
        chk({31'h0, e}, 32'h1); // unmapped refused
        chk(q, 32'h0); // unmapped reads zero
        for (int t = 0; t < 2; t++) begin
            wr(OFS_CNT[t], 32'h0);
            wr(OFS_CTL[t], 32'h1f);
        end
        ext_f <= 4'hf;
        for (int i = 0; i < 6; i++) begin
            rd(OFS_VEC);
            chk(q, {16'h0, VEC_CODE[i]}); // smallest first
            if (i < 3) begin
                ext_f[i] <= 1'b0;
            end else if (i == 5) begin
                ext_f[3] <= 1'b0;
            end
        end
        rd(OFS_VEC);
        chk(q, 32'h0); // none left pending
        chk({28'h0, clr_seen}, 32'hf); // outside flags cleared
        rd(OFS_CTL[0]);
        chk(q & 32'h1, 32'h0); // read clears timer flag
        wr(OFS_CTL[1], 32'h0);
        // Copy must see the cleared settings before the lock rises
        cyc(1);
        lock <= 1'b1;
        // Flag written high, so a held-rate event cannot change it
        wr(OFS_CTL[1], 32'h1d);
        rd(OFS_CTL[1]);
        chk(q, 32'h1d); // register still writable
        wr(OFS_MASK, 32'h2);
        wr(OFS_CNT[1], 32'h0);
        wr(OFS_STAT, 32'h3);
        wait_irq(0, 3 * 125 + 8); // held divide by 2
        @(posedge clk);
        dexit <= 1'b1;
        @(posedge clk);
        dexit <= 1'b0;
        lock <= 1'b0;
        rd(OFS_CTL[1]);
        chk(q, 32'h0); // contents not retained
        end_of_test();
    end
endmodule
